// ==== inc/cepc_pkg.sv ====
// Constants for the capture edge mode and PWM enable control block
package cepc_pkg;
    localparam int CEPC_TIMEBASE_W = 16;
    localparam int CEPC_PRESCALE_W = 4;
    localparam logic [1:0] CEPC_MODE_FALL = 2'h0;
    localparam logic [1:0] CEPC_MODE_RISE = 2'h1;
    localparam logic [1:0] CEPC_MODE_RISE4 = 2'h2;
    localparam logic [1:0] CEPC_MODE_RISE16 = 2'h3;
    localparam logic [3:0] CEPC_COUNT4_LAST = 4'h3;
    localparam logic [3:0] CEPC_COUNT16_LAST = 4'hf;
    localparam int CEPC_CH4_MODE_HI = 4;
    localparam int CEPC_CH4_MODE_LO = 3;
    localparam int CEPC_CH3_MODE_HI = 2;
    localparam int CEPC_CH3_MODE_LO = 1;
    localparam int CEPC_PWM_EN_BIT = 0;
    localparam logic [4:0] CEPC_CTRL_RESET = 5'h00;
    localparam logic [15:0] CEPC_VALUE_RESET = 16'h0000;
    localparam int CEPC_NUM_CH = 2;
endpackage

// ==== hw/cepc_ctrl.sv ====
// Capture channels 3 and 4 edge modes, overflow, and PWM3 pin enable
//
// Operation
// - Channel 4 mode at bits 4:3 picks falling, rising, every 4th or every 16th rising edge.
// - Channel 3 mode at bits 2:1 uses the same encoding as channel 4.
// - Prescaled modes count rising edges and capture only on the 4th or 16th.
// - With the PWM3 enable bit at bit 0 set, PWM drives the shared pin and its direction bit is ignored.
// - With the enable clear, PWM is off and the pin follows its port direction bit.
// - A capture arriving before both bytes of the last value were read sets the overflow flag.
// - After overflow the oldest unread value is kept until both bytes are read.
`timescale 1ns/10ps
module cepc_ctrl import cepc_pkg::*; (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [4:0] ctrl_in,
    input wire logic [1:0] cap_pin_in,
    input wire logic [15:0] capture_timebase_in,
    input wire logic [1:0] read_low_in,
    input wire logic [1:0] read_high_in,
    input wire logic [1:0] ovf_clear_in,
    input wire logic pwm_ch3_in,
    input wire logic port_g_data_in,
    input wire logic port_g_direction_in,
    output logic [15:0] cap_ch3_value_pair_out,
    output logic [15:0] cap_ch4_value_pair_out,
    output logic cap_ch3_overflow_flag_out,
    output logic cap_ch4_overflow_flag_out,
    output logic [1:0] capture_event_out,
    output logic shared_pwm_pin_out,
    output logic shared_pwm_pin_oe_n_out
);
    // Control field decode
    wire [1:0] cap_ch4_edge_mode = ctrl_in[CEPC_CH4_MODE_HI:CEPC_CH4_MODE_LO];
    wire [1:0] cap_ch3_edge_mode = ctrl_in[CEPC_CH3_MODE_HI:CEPC_CH3_MODE_LO];
    wire pwm_ch3_enable = ctrl_in[CEPC_PWM_EN_BIT];

    // Channel index 0 is channel 3, index 1 is channel 4
    wire [1:0] mode [CEPC_NUM_CH];
    assign mode[0] = cap_ch3_edge_mode;
    assign mode[1] = cap_ch4_edge_mode;

    // Per-channel results gathered for the output stage
    wire [15:0] value [CEPC_NUM_CH];
    wire [1:0] ovf;
    wire [1:0] evt;

    // Shared pin selection
    wire next_pin = pwm_ch3_enable ? pwm_ch3_in : port_g_data_in;
    // Direction bit: 1 means input, as on the port
    wire next_pin_oe_n = pwm_ch3_enable ? 1'b0 : port_g_direction_in;

    genvar g;
    generate
        for (g = 0; g < CEPC_NUM_CH; g++) begin : gen_ch
            // Synchroniser and edge history
            logic sync1;
            logic sync2;
            logic prev;

            // Prescaler and read tracking
            logic [3:0] pre_cnt;
            logic lo_read;
            logic hi_read;
            logic unread;

            // Captured value, overflow flag and event pulse
            logic [15:0] value_r;
            logic ovf_r;
            logic evt_r;

            // Edges are taken from the second flop only, never from the first
            wire rise = sync2 & ~prev;
            wire fall = ~sync2 & prev;

            // Mode decode
            wire mode_fall = (mode[g] == CEPC_MODE_FALL);
            wire mode_rise = (mode[g] == CEPC_MODE_RISE);
            wire mode_rise4 = (mode[g] == CEPC_MODE_RISE4);
            wire prescaled = mode[g][1];

            // Prescaler terminal count
            wire [3:0] last = mode_rise4 ? CEPC_COUNT4_LAST : CEPC_COUNT16_LAST;
            wire pre_hit = prescaled & rise & (pre_cnt == last);

            // Capture event for the selected mode
            wire cap_evt = mode_fall ? fall :
                           mode_rise ? rise : pre_hit;

            // Counter restarts outside prescaled modes; a direct change between the two prescaled modes keeps the count
            wire [3:0] pre_inc = pre_cnt + 4'h1;
            wire [3:0] pre_step = pre_hit ? 4'h0 : pre_inc;
            wire [3:0] pre_keep = rise ? pre_step : pre_cnt;
            wire [3:0] next_pre_cnt = prescaled ? pre_keep : 4'h0;

            // Both bytes read, in either order, frees the register
            wire lo_seen = lo_read | read_low_in[g];
            wire hi_seen = hi_read | read_high_in[g];
            wire both_read = lo_seen & hi_seen;

            // A read in the load cycle belongs to the old value and is dropped
            wire load = cap_evt & ~unread;
            wire next_unread = load | (unread & ~both_read);
            wire next_lo_read = ~load & ~both_read & lo_seen;
            wire next_hi_read = ~load & ~both_read & hi_seen;
            wire [15:0] next_value = load ? capture_timebase_in : value_r;

            // Set wins over a clear in the same cycle
            wire ovf_set = cap_evt & unread;
            wire next_ovf = ovf_set | (ovf_r & ~ovf_clear_in[g]);

            always_ff @(posedge clk_in) begin
                if (!rstn_in) begin
                    sync1 <= 1'b0;
                    sync2 <= 1'b0;
                    prev <= 1'b0;
                end else begin
                    sync1 <= cap_pin_in[g];
                    sync2 <= sync1;
                    prev <= sync2;
                end
            end

            always_ff @(posedge clk_in) begin
                if (!rstn_in) begin
                    pre_cnt <= 4'h0;
                end else begin
                    pre_cnt <= next_pre_cnt;
                end
            end

            always_ff @(posedge clk_in) begin
                if (!rstn_in) begin
                    lo_read <= 1'b0;
                    hi_read <= 1'b0;
                    unread <= 1'b0;
                end else begin
                    lo_read <= next_lo_read;
                    hi_read <= next_hi_read;
                    unread <= next_unread;
                end
            end

            always_ff @(posedge clk_in) begin
                if (!rstn_in) begin
                    value_r <= CEPC_VALUE_RESET;
                end else begin
                    value_r <= next_value;
                end
            end

            // The event pulse is shown even when the value is refused
            always_ff @(posedge clk_in) begin
                if (!rstn_in) begin
                    ovf_r <= 1'b0;
                    evt_r <= 1'b0;
                end else begin
                    ovf_r <= next_ovf;
                    evt_r <= cap_evt;
                end
            end

            assign value[g] = value_r;
            assign ovf[g] = ovf_r;
            assign evt[g] = evt_r;
        end
    endgenerate

    // Output stage: every output straight from a flop
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            cap_ch3_value_pair_out <= CEPC_VALUE_RESET;
            cap_ch4_value_pair_out <= CEPC_VALUE_RESET;
        end else begin
            cap_ch3_value_pair_out <= value[0];
            cap_ch4_value_pair_out <= value[1];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            cap_ch3_overflow_flag_out <= 1'b0;
            cap_ch4_overflow_flag_out <= 1'b0;
            capture_event_out <= 2'h0;
        end else begin
            cap_ch3_overflow_flag_out <= ovf[0];
            cap_ch4_overflow_flag_out <= ovf[1];
            capture_event_out <= evt;
        end
    end

    // Pin released (input) during reset so nothing is driven before software decides
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            shared_pwm_pin_out <= 1'b0;
            shared_pwm_pin_oe_n_out <= 1'b1;
        end else begin
            shared_pwm_pin_out <= next_pin;
            shared_pwm_pin_oe_n_out <= next_pin_oe_n;
        end
    end
endmodule

// ==== sim/cepc_ctrl_asserts.sv ====
// Checker for capture loads, overflow and shared pin control
`timescale 1ns/10ps
module cepc_ctrl_chk (input wire logic clk_in, rstn_in, input wire logic [4:0] ctrl_in,
    input wire logic [15:0] capture_timebase_in, cap_ch3_value_pair_out, cap_ch4_value_pair_out,
    input wire logic [1:0] ovf_clear_in, capture_event_out, input wire logic pwm_ch3_in, port_g_data_in,
    input wire logic port_g_direction_in, cap_ch3_overflow_flag_out, cap_ch4_overflow_flag_out,
    input wire logic shared_pwm_pin_out, shared_pwm_pin_oe_n_out);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    AST_PWM_OE: assert property (ctrl_in[0] |=> !shared_pwm_pin_oe_n_out) else $error("oe_n not low");
    AST_PWM_PIN: assert property (ctrl_in[0] |=> shared_pwm_pin_out == $past(pwm_ch3_in)) else $error("pin bad");
    AST_GPIO: assert property (!ctrl_in[0] |=> shared_pwm_pin_oe_n_out == $past(port_g_direction_in)
        && shared_pwm_pin_out == $past(port_g_data_in)) else $error("pin not port");
    AST_LOAD3: assert property ($past(rstn_in) && !$stable(cap_ch3_value_pair_out) |-> capture_event_out[0]
        && cap_ch3_value_pair_out == $past(capture_timebase_in, 2)) else $error("ch3 bad load");
    AST_LOAD4: assert property ($past(rstn_in) && !$stable(cap_ch4_value_pair_out) |-> capture_event_out[1]
        && cap_ch4_value_pair_out == $past(capture_timebase_in, 2)) else $error("ch4 bad load");
    AST_OVF_SET: assert property ($rose(cap_ch3_overflow_flag_out) |-> capture_event_out[0]
        || $past(capture_event_out[0])) else $error("ch3 ovf without event");
    AST_OVF_HOLD: assert property (cap_ch4_overflow_flag_out && !ovf_clear_in[1] && !$past(ovf_clear_in[1])
        |=> cap_ch4_overflow_flag_out)
        else $error("ch4 ovf dropped");
    AST_EVT: assert property (capture_event_out[1] |=> !capture_event_out[1]) else $error("ch4 event long");
    COV_EVT: cover property (capture_event_out[0]);
    COV_OVF: cover property ($rose(cap_ch4_overflow_flag_out));
    COV_PWM: cover property (ctrl_in[0] ##1 !shared_pwm_pin_oe_n_out);
endmodule
bind cepc_ctrl cepc_ctrl_chk chk_u (.*);

// ==== sim/cepc_pin_src.sv ====
// Capture pin source: square wave while running
`timescale 1ns/10ps
module cepc_pin_src (input wire logic clk_in, input wire logic run_in, output logic [1:0] pin_out);
    initial pin_out = 2'h0;
    // Finishing the high phase keeps rising and falling counts equal
    always @(posedge clk_in) if (run_in || pin_out[0]) pin_out <= ~pin_out;
endmodule

// ==== sim/tb_capture_edge_pwm_enable_ctrl.sv ====
// Testbench for capture edge modes, overflow and PWM pin control
`timescale 1ns/10ps
module tb_capture_edge_pwm_enable_ctrl import cepc_pkg::*;;
    logic clk_in = 0, rstn_in = 0, run = 0, pwm = 0, pdat = 0, pdir = 0, f3, f4, pin, oe;
    logic [4:0] ctrl = 5'h00;
    logic [1:0] pins, ev, rd = 2'h0, oc = 2'h0;
    logic [15:0] tb = 16'h0000, v3, v4, t3 = 16'h0000;
    int errors = 0, n_tests = 0, c3 = 0, c4 = 0;
    always #20 clk_in = ~clk_in;
    always @(posedge clk_in) tb <= tb + 16'h0001;
    always @(negedge clk_in) begin c3 += ev[0]; c4 += ev[1]; end
    cepc_pin_src src_u (.clk_in(clk_in), .run_in(run), .pin_out(pins));
    cepc_ctrl dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .ctrl_in(ctrl), .cap_pin_in(pins),
        .capture_timebase_in(tb), .read_low_in(rd), .read_high_in(rd), .ovf_clear_in(oc), .pwm_ch3_in(pwm),
        .port_g_data_in(pdat), .port_g_direction_in(pdir), .cap_ch3_value_pair_out(v3), .cap_ch4_value_pair_out(v4),
        .cap_ch3_overflow_flag_out(f3), .cap_ch4_overflow_flag_out(f4), .capture_event_out(ev),
        .shared_pwm_pin_out(pin), .shared_pwm_pin_oe_n_out(oe));
    task cyc(int n); repeat (n) @(posedge clk_in); endtask
    task chk(string s, logic [15:0] e, logic [15:0] g);
        @(negedge clk_in);
        n_tests++;
        if (g !== e) begin errors++; $display("[FAIL] %s exp %h got %h", s, e, g); end
    endtask
    task complete_run;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin #100000; errors++; complete_run; end
    initial begin
        cyc(20); rstn_in <= 1;
        for (int m = 0; m < 4; m++) begin
            cyc(1); ctrl <= {m[1:0], m[1:0], 1'b0}; cyc(4); c3 = 0; c4 = 0;
            run <= 1; cyc(64); run <= 0; cyc(12);
            chk("ch3 events", 16'(m < 2 ? 32 : 32 >> (2 * m - 2)), 16'(c3));
            chk("ch4 events", 16'(m < 2 ? 32 : 32 >> (2 * m - 2)), 16'(c4));
        end
        chk("ch3 ovf", 16'h0001, {15'h0, f3});
        cyc(1); rd <= 2'h3; cyc(1); rd <= 2'h0; oc <= 2'h3; cyc(1); oc <= 2'h0; cyc(2);
        chk("ch4 ovf clear", 16'h0000, {15'h0, f4});
        ctrl <= 5'h0a; run <= 1; cyc(1); @(negedge clk_in) t3 = tb; cyc(1); run <= 0; cyc(12);
        chk("ch3 ovf after read", 16'h0000, {15'h0, f3});
        chk("ch3 value", t3 + 16'h0002, v3);
        chk("ch4 value", t3 + 16'h0002, v4);
        cyc(1); ctrl <= 5'h01; pwm <= 1; pdir <= 1; cyc(2);
        chk("pwm pin", 16'h0001, {15'h0, pin});
        chk("pwm oe_n", 16'h0000, {15'h0, oe});
        cyc(1); ctrl <= 5'h00; pdat <= 0; cyc(2);
        chk("port pin", 16'h0000, {15'h0, pin});
        chk("port oe_n", 16'h0001, {15'h0, oe});
        complete_run;
    end
endmodule
